// >>> hw/sysc_config.sv
// system configuration register with strap load, lock and controlled functions
//
// Functional notes
// - register can be set or cleared one bit at a time.
// - value after reset depends on port 0 pin levels.
// - some bits load from port 0 and external access pins at reset.
// - after end-of-init, all writes to the register are ignored.
// - extension peripheral enable bit gates access to extension peripherals.
// - bidir reset bit clear: reset pin stays input only.
// - bidir reset bit set: pin driven low 1024 clock phases per reset.
// - watchdog on, PLL bypassed: 1 us crystal silence switches to PLL.
// - watchdog off, PLL bypassed: crystal clocks CPU, PLL powered down.
// - power-down config 0: enter only when NMI pin low.
// - power-down config 0: only external reset wakes the device.
// - power-down config 1: enter only when enabled fast interrupts inactive.
// - power-down config 1: any enabled fast interrupt asserted wakes device.
// - chip-select config 0: chip selects change one phase after ALE rise; the code rounds this up to one full cycle (two phases).
// - chip-select config 1: chip selects change with ALE rise.
// - end-of-init is signalled on the reset output pin.
`timescale 1ns/1ps
`default_nettype none

module sysc_config #(
    parameter int NUM_FAST_INT = 8,
    parameter int NUM_CS       = 5
) (
    // clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_b,
    // register port
    input  wire sysc_pkg::sysc_bus_req_s   bus_req,
    output logic [15:0]                    bus_rdata,
    // bit-addressed access
    input  wire sysc_pkg::sysc_bit_op_s    bit_op,
    // strap pins
    input  wire logic [15:0]               config_port_pins,
    input  wire logic                      external_access_pin,
    // cpu events
    input  wire logic                      end_of_init_instruction,
    input  wire logic                      power_down_instruction,
    input  wire logic                      sw_reset_req,
    input  wire logic                      wdt_reset_req,
    // reset pins
    input  wire logic                      reset_input_pin_sense,
    output logic                           reset_input_pin_drive,
    output logic                           reset_input_pin_oe,
    output logic                           reset_output_pin_b,
    // extension bus gate
    input  wire logic                      ext_periph_req,
    output logic                           ext_periph_grant,
    output logic                           ext_peripheral_enable,
    // clock control
    input  wire logic                      crystal_input,
    input  wire logic                      pll_bypass,
    output logic                           cpu_clk_from_pll,
    output logic                           pll_power_off,
    // power-down
    input  wire logic                      nmi_pin_b,
    input  wire logic [NUM_FAST_INT-1:0]   fast_ext_int_pin,
    input  wire logic [NUM_FAST_INT-1:0]   fast_int_enable,
    output logic                           power_down,
    // chip selects
    input  wire logic                      ale,
    input  wire logic [NUM_CS-1:0]         cs_decode_b,
    output logic [NUM_CS-1:0]              chip_select_outputs_b,
    // raw configuration view
    output logic [15:0]                    system_configuration
);
    import sysc_pkg::*;

    // ******************************************************************
    // configuration register
    // ******************************************************************
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic        strap_done_q;
    logic        locked_q;
    logic        cfg_wr;

    assign cfg_wr = bus_req.wr && (bus_req.addr == SYSC_CFG_OFS);

    always_comb begin
        cfg_d = cfg_q;
        if (!strap_done_q) begin
            cfg_d[SYSC_ROM_EN_BIT]   = external_access_pin;
            cfg_d[SYSC_BYTE_DIS_BIT] = config_port_pins[SYSC_STRAP_BYTE_DIS_PIN];
            cfg_d[SYSC_WR_CFG_BIT]   = ~config_port_pins[SYSC_STRAP_WR_CFG_PIN];
        end else if (!locked_q) begin
            if (cfg_wr) begin
                cfg_d = bus_req.wdata;
            end else if (bit_op.wr) begin
                cfg_d[bit_op.idx] = bit_op.val;
            end
        end
    end

    // straps are caught by the first edge after release, never by the reset itself
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= SYSC_CFG_RST;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            strap_done_q <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
        end
    end

    // a write in the same cycle as end-of-init still lands; the lock follows
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            locked_q <= 1'b0;
        end else if (end_of_init_instruction && strap_done_q) begin
            locked_q <= 1'b1;
        end
    end

    // end-of-init releases the reset output
    assign reset_output_pin_b = locked_q;
    assign system_configuration = cfg_q;

    // ******************************************************************
    // register read port
    // ******************************************************************
    logic [15:0] status_word;
    logic        pulling;

    assign status_word = {11'h000, reset_input_pin_sense, pulling, cpu_clk_from_pll, power_down,
                          locked_q};

    // unmapped reads return zero, so a stale word never leaks onto the bus
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata <= 16'h0000;
        end else if (bus_req.rd && bus_req.addr == SYSC_CFG_OFS) begin
            bus_rdata <= cfg_q;
        end else if (bus_req.rd && bus_req.addr == SYSC_STATUS_OFS) begin
            bus_rdata <= status_word;
        end else begin
            bus_rdata <= 16'h0000;
        end
    end

    // ******************************************************************
    // extension peripheral gate
    // ******************************************************************
    assign ext_peripheral_enable = cfg_q[SYSC_EXT_PERIPH_EN_BIT];
    assign ext_periph_grant      = ext_periph_req && cfg_q[SYSC_EXT_PERIPH_EN_BIT];

    // ******************************************************************
    // bidirectional reset pin
    // ******************************************************************
    localparam logic [9:0] PULL_LAST = 10'(SYSC_RST_PULL_CYC - 1);

    sysc_rstpin_e rst_state_q;
    logic [9:0]   pull_cnt_q;

    // the pin is only ever pulled low; its level is reported in the status word
    // requests during a pull are ignored, so a pull is never stretched
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_state_q <= SYSC_RST_IDLE;
            pull_cnt_q  <= 10'h000;
        end else begin
            case (rst_state_q)
                SYSC_RST_IDLE: begin
                    if ((sw_reset_req || wdt_reset_req) && cfg_q[SYSC_BIDIR_RST_BIT]) begin
                        rst_state_q <= SYSC_RST_PULL;
                        pull_cnt_q  <= 10'h000;
                    end
                end
                SYSC_RST_PULL: begin
                    if (pull_cnt_q == PULL_LAST) begin
                        rst_state_q <= SYSC_RST_IDLE;
                    end else begin
                        pull_cnt_q <= pull_cnt_q + 10'h001;
                    end
                end
                default: begin
                    rst_state_q <= SYSC_RST_IDLE;
                end
            endcase
        end
    end

    assign pulling               = (rst_state_q == SYSC_RST_PULL);
    assign reset_input_pin_oe    = pulling;
    assign reset_input_pin_drive = 1'b0;

    // ******************************************************************
    // oscillator watchdog
    // ******************************************************************
    localparam logic [4:0] XTAL_IDLE_LAST = 5'(SYSC_XTAL_IDLE_CYC);

    logic       xtal_prev_q;
    logic [4:0] idle_cnt_q;
    logic       clk_pll_q;
    logic       osc_wd_active;

    assign osc_wd_active = !cfg_q[SYSC_OSC_WD_DIS_BIT] && pll_bypass;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            xtal_prev_q <= 1'b0;
        end else begin
            xtal_prev_q <= crystal_input;
        end
    end

    // a change restarts the silence count, which saturates instead of wrapping
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            idle_cnt_q <= 5'h00;
        end else if (!osc_wd_active || crystal_input != xtal_prev_q) begin
            idle_cnt_q <= 5'h00;
        end else if (idle_cnt_q != XTAL_IDLE_LAST) begin
            idle_cnt_q <= idle_cnt_q + 5'h01;
        end
    end

    // the fallback is sticky: only a reset gives the crystal back
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            clk_pll_q <= 1'b0;
        end else if (osc_wd_active && idle_cnt_q == XTAL_IDLE_LAST) begin
            clk_pll_q <= 1'b1;
        end
    end

    assign cpu_clk_from_pll = clk_pll_q;
    assign pll_power_off    = cfg_q[SYSC_OSC_WD_DIS_BIT] && pll_bypass && !clk_pll_q;

    // ******************************************************************
    // power-down control
    // ******************************************************************
    sysc_pwr_e               pwr_q;
    logic                    any_fast_active;
    logic                    pwd_entry_ok;
    logic [NUM_FAST_INT-1:0] fast_hit;

    // per-pin gate: a disabled pin neither blocks entry nor wakes the device
    for (genvar g = 0; g < NUM_FAST_INT; g++) begin : g_fast_int
        assign fast_hit[g] = fast_ext_int_pin[g] && fast_int_enable[g];
    end

    assign any_fast_active = |fast_hit;

    always_comb begin
        if (cfg_q[SYSC_PWD_CFG_BIT]) begin
            pwd_entry_ok = !any_fast_active;
        end else begin
            pwd_entry_ok = !nmi_pin_b;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pwr_q <= SYSC_PWR_RUN;
        end else begin
            case (pwr_q)
                SYSC_PWR_RUN: begin
                    if (power_down_instruction && pwd_entry_ok) begin
                        pwr_q <= SYSC_PWR_DOWN;
                    end
                end
                SYSC_PWR_DOWN: begin
                    if (cfg_q[SYSC_PWD_CFG_BIT] && any_fast_active) begin
                        pwr_q <= SYSC_PWR_RUN;
                    end
                end
                default: begin
                    pwr_q <= SYSC_PWR_RUN;
                end
            endcase
        end
    end

    assign power_down = (pwr_q == SYSC_PWR_DOWN);

    // ******************************************************************
    // chip-select timing
    // ******************************************************************
    // one phase is half a cycle here, so the latched path rounds up to a cycle
    logic              ale_q;
    logic              ale_rise;
    logic              cs_pend_q;
    logic [NUM_CS-1:0] cs_hold_q;
    logic [NUM_CS-1:0] cs_q;

    assign ale_rise = ale && !ale_q;

    // detector idles low like the pin, so reset brings no false rise
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ale_q <= 1'b0;
        end else begin
            ale_q <= ale;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cs_pend_q <= 1'b0;
        end else begin
            cs_pend_q <= ale_rise && !cfg_q[SYSC_CS_CFG_BIT] && (SYSC_CS_LATCH_CYC > 0);
        end
    end

    // selects are active low and park high out of reset
    for (genvar g = 0; g < NUM_CS; g++) begin : g_cs_lane
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                cs_hold_q[g] <= 1'b1;
            end else if (ale_rise && !cfg_q[SYSC_CS_CFG_BIT]) begin
                cs_hold_q[g] <= cs_decode_b[g];
            end
        end

        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                cs_q[g] <= 1'b1;
            end else if (ale_rise && cfg_q[SYSC_CS_CFG_BIT]) begin
                cs_q[g] <= cs_decode_b[g];
            end else if (cs_pend_q) begin
                cs_q[g] <= cs_hold_q[g];
            end
        end
    end

    assign chip_select_outputs_b = cs_q;

endmodule

`default_nettype wire

// >>> hw/sysc_pkg.sv
// shared constants and carriers for the system configuration register block
package sysc_pkg;

    // ******************************************************************
    // register map
    // ******************************************************************
    localparam logic [15:0] SYSC_CFG_OFS    = 16'hff12;
    localparam logic [15:0] SYSC_STATUS_OFS = 16'hff14;
    localparam logic [15:0] SYSC_CFG_RST    = 16'h0000;

    // ******************************************************************
    // field positions of system_configuration
    // ******************************************************************
    localparam int SYSC_PERIPH_SHARE_BIT = 0;
    localparam int SYSC_VISIBLE_BIT      = 1;
    localparam int SYSC_EXT_PERIPH_EN_BIT = 2;
    localparam int SYSC_BIDIR_RST_BIT    = 3;
    localparam int SYSC_OSC_WD_DIS_BIT   = 4;
    localparam int SYSC_PWD_CFG_BIT      = 5;
    localparam int SYSC_CS_CFG_BIT       = 6;
    localparam int SYSC_WR_CFG_BIT       = 7;
    localparam int SYSC_CLK_OUT_BIT      = 8;
    localparam int SYSC_BYTE_DIS_BIT     = 9;
    localparam int SYSC_ROM_EN_BIT       = 10;
    localparam int SYSC_SEG_DIS_BIT      = 11;
    localparam int SYSC_ROM_SEG1_BIT     = 12;

    // strap pin positions on config_port_pins
    localparam int SYSC_STRAP_BYTE_DIS_PIN = 7;
    localparam int SYSC_STRAP_WR_CFG_PIN   = 5;

    // ******************************************************************
    // timing
    // ******************************************************************
    localparam int SYSC_CLK_NS         = 50;
    localparam int SYSC_PHASE_NS        = SYSC_CLK_NS / 2;
    localparam int SYSC_RST_PULL_PHASES = 1024;
    localparam int SYSC_RST_PULL_CYC    =
        (SYSC_RST_PULL_PHASES * SYSC_PHASE_NS + SYSC_CLK_NS - 1) / SYSC_CLK_NS;
    localparam int SYSC_XTAL_IDLE_NS    = 1000;
    localparam int SYSC_XTAL_IDLE_CYC   = (SYSC_XTAL_IDLE_NS + SYSC_CLK_NS - 1) / SYSC_CLK_NS;
    localparam int SYSC_CS_LATCH_PHASES = 1;
    localparam int SYSC_CS_LATCH_CYC    =
        (SYSC_CS_LATCH_PHASES * SYSC_PHASE_NS + SYSC_CLK_NS - 1) / SYSC_CLK_NS;

    // ******************************************************************
    // carriers and states
    // ******************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } sysc_bus_req_s;

    typedef struct packed {
        logic       wr;
        logic [3:0] idx;
        logic       val;
    } sysc_bit_op_s;

    typedef enum logic [1:0] {
        SYSC_PWR_RUN  = 2'b00,
        SYSC_PWR_DOWN = 2'b01
    } sysc_pwr_e;

    typedef enum logic [1:0] {
        SYSC_RST_IDLE = 2'b00,
        SYSC_RST_PULL = 2'b01
    } sysc_rstpin_e;

endpackage

// >>> sim/sysc_config_sva.sv
// port checker for the system configuration register
`timescale 1ns/1ps
`default_nettype none

module sysc_config_sva #(
    parameter int NUM_FAST_INT = 8,
    parameter int NUM_CS       = 5
) (
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    rst_b,
    // reset pins and events
    input wire logic                    sw_reset_req,
    input wire logic                    wdt_reset_req,
    input wire logic                    reset_input_pin_oe,
    input wire logic                    end_of_init_instruction,
    input wire logic                    reset_output_pin_b,
    // gate and power-down
    input wire logic                    ext_periph_req,
    input wire logic                    ext_periph_grant,
    input wire logic                    power_down_instruction,
    input wire logic                    nmi_pin_b,
    input wire logic [NUM_FAST_INT-1:0] fast_ext_int_pin,
    input wire logic [NUM_FAST_INT-1:0] fast_int_enable,
    input wire logic                    power_down,
    // chip selects and register
    input wire logic                    ale,
    input wire logic [NUM_CS-1:0]       cs_decode_b,
    input wire logic [NUM_CS-1:0]       chip_select_outputs_b,
    input wire logic [15:0]             system_configuration
);
    // ****************
    // helper logic
    // ****************
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    logic [15:0] cf;
    logic        fire;
    logic [9:0]  oe_n_q;
    assign cf = system_configuration;
    assign fire = |(fast_ext_int_pin & fast_int_enable);
    // length of the current pull, read at its falling edge
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) oe_n_q <= 10'h000;
        else if (reset_input_pin_oe) oe_n_q <= oe_n_q + 10'h001;
        else oe_n_q <= 10'h000;
    end

    // ****************
    // properties
    // ****************
    property p_grant; ext_periph_grant == (ext_periph_req && cf[2]); endproperty
    a_grant: assert property (p_grant) else $error("grant wrong");
    property p_oe_off; (sw_reset_req || wdt_reset_req) && !cf[3] && !reset_input_pin_oe
        |=> !reset_input_pin_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin pulled");
    property p_oe_len; $fell(reset_input_pin_oe) |-> oe_n_q == 10'h200; endproperty
    a_oe_len: assert property (p_oe_len) else $error("pull length");
    property p_lock; reset_output_pin_b && $past(reset_output_pin_b) |-> $stable(cf); endproperty
    a_lock: assert property (p_lock) else $error("changed after lock");
    property p_eoi; end_of_init_instruction |=> reset_output_pin_b; endproperty
    a_eoi: assert property (p_eoi) else $error("no end of init");
    property p_pd_nmi; power_down_instruction && !power_down && !cf[5]
        |=> power_down == !$past(nmi_pin_b); endproperty
    a_pd_nmi: assert property (p_pd_nmi) else $error("entry vs nmi");
    property p_pd_wake; power_down && cf[5] && fire |=> !power_down; endproperty
    a_pd_wake: assert property (p_pd_wake) else $error("no wake");
    property p_cs_lat; !cf[6] && ale && !$past(ale)
        |=> ##1 chip_select_outputs_b == $past(cs_decode_b, 2); endproperty
    a_cs_lat: assert property (p_cs_lat) else $error("latched cs");
    property p_cs_unl; cf[6] && ale && !$past(ale)
        |=> chip_select_outputs_b == $past(cs_decode_b); endproperty
    a_cs_unl: assert property (p_cs_unl) else $error("unlatched cs");
    c_pull: cover property ($fell(reset_input_pin_oe));
    c_pd: cover property ($fell(power_down));
    c_lock: cover property ($rose(reset_output_pin_b));
endmodule

bind sysc_config sysc_config_sva #(.NUM_FAST_INT(NUM_FAST_INT), .NUM_CS(NUM_CS)) i_sysc_config_sva (
    .clk_sys(clk_sys), .rst_b(rst_b), .sw_reset_req(sw_reset_req),
    .wdt_reset_req(wdt_reset_req), .reset_input_pin_oe(reset_input_pin_oe),
    .end_of_init_instruction(end_of_init_instruction), .reset_output_pin_b(reset_output_pin_b),
    .ext_periph_req(ext_periph_req), .ext_periph_grant(ext_periph_grant),
    .power_down_instruction(power_down_instruction), .nmi_pin_b(nmi_pin_b),
    .fast_ext_int_pin(fast_ext_int_pin), .fast_int_enable(fast_int_enable),
    .power_down(power_down), .ale(ale), .cs_decode_b(cs_decode_b),
    .chip_select_outputs_b(chip_select_outputs_b), .system_configuration(system_configuration)
);
`default_nettype wire

// >>> sim/testbench.sv
// self-checking bench for the system configuration register
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import sysc_pkg::*;

    // ****************
    // signals
    // ****************
    logic          clk_sys = 1'b0;
    logic          rst_b   = 1'b0;
    sysc_bus_req_s bq      = '0;
    sysc_bit_op_s  bo      = '0;
    logic [15:0]   pins    = 16'h0080;
    logic [7:0]    fint    = 8'h00;
    logic [7:0]    fen     = 8'h01;
    logic [4:0]    csd     = 5'h1f;
    logic          ext_acc = 1'b1, eoi = 1'b0, pdi = 1'b0, swr = 1'b0, wdr = 1'b0, run = 1'b1;
    logic          xreq = 1'b1, xtal = 1'b0, byp = 1'b1, nmi_b = 1'b1, ale = 1'b0;
    logic [15:0]   rdata, cfg, rv;
    logic [4:0]    cso;
    logic          oe, drv, rob, xgnt, xen, pll, poff, pd;
    int            num_errors = 0;
    int            n_compared = 0;

    always #25 clk_sys = ~clk_sys;
    // crystal keeps toggling so the oscillator watchdog stays quiet until tested
    always @(posedge clk_sys) if (run) xtal <= ~xtal;

    sysc_config i_sysc_config (
        .clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bq), .bus_rdata(rdata), .bit_op(bo),
        .config_port_pins(pins), .external_access_pin(ext_acc), .end_of_init_instruction(eoi),
        .power_down_instruction(pdi), .sw_reset_req(swr), .wdt_reset_req(wdr),
        .reset_input_pin_sense(!oe), .reset_input_pin_drive(drv), .reset_input_pin_oe(oe),
        .reset_output_pin_b(rob), .ext_periph_req(xreq), .ext_periph_grant(xgnt),
        .ext_peripheral_enable(xen), .crystal_input(xtal), .pll_bypass(byp),
        .cpu_clk_from_pll(pll), .pll_power_off(poff), .nmi_pin_b(nmi_b),
        .fast_ext_int_pin(fint), .fast_int_enable(fen), .power_down(pd), .ale(ale),
        .cs_decode_b(csd), .chip_select_outputs_b(cso), .system_configuration(cfg)
    );

    // ****************
    // tasks
    // ****************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // word write when w is high, else bit write of d[0] to bit a[3:0]
    task automatic put(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        if (w) bq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        else bo <= '{wr: 1'b1, idx: a[3:0], val: d[0]};
        @(posedge clk_sys);
        bq.wr <= 1'b0;
        bo.wr <= 1'b0;
        @(negedge clk_sys);
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge clk_sys);
        bq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bq.rd <= 1'b0;
        @(negedge clk_sys);
        rv = rdata;
    endtask

    // one-cycle pulse on {end of init, power down, sw reset, wdt reset}
    task automatic kick(input logic [3:0] s);
        @(posedge clk_sys);
        {eoi, pdi, swr, wdr} <= s;
        @(posedge clk_sys);
        {eoi, pdi, swr, wdr} <= 4'h0;
        @(negedge clk_sys);
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic t_rpin(input logic en, input logic [15:0] exp);
        logic [15:0] n;
        put(1'b0, 16'h0003, {15'h0, en});
        kick({2'b00, !en, en});
        chk({oe, drv}, {en, 1'b0});
        n = {15'h0, oe};
        repeat (600) begin
            @(negedge clk_sys);
            n = n + {15'h0, oe};
        end
        chk(n, exp);
    endtask

    task automatic t_cs(input logic m, input logic [4:0] d, input logic [4:0] o);
        put(1'b0, 16'h0006, {15'h0, m});
        @(posedge clk_sys);
        {ale, csd} <= {1'b1, d};
        @(posedge clk_sys);
        csd <= ~d;
        @(negedge clk_sys);
        chk(cso, m ? d : o);
        @(negedge clk_sys);
        chk(cso, d);
        ale <= 1'b0;
    endtask

    task automatic wrap_up();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        do_reset();
        chk(cfg, 16'h0680);
        chk(rob, 1'b0);
        pins <= 16'h0020;
        ext_acc <= 1'b0;
        do_reset();
        chk(cfg, 16'h0000);
        put(1'b1, SYSC_CFG_OFS, 16'h1f03);
        rd(SYSC_CFG_OFS);
        chk(rv, 16'h1f03);
        rd(16'hff16);
        chk(rv, 16'h0000);
        put(1'b0, 16'h0002, 16'h0001);
        put(1'b0, 16'h0000, 16'h0000);
        chk({xen, xgnt, cfg}, 18'h31f06);
        xreq <= 1'b0;
        @(negedge clk_sys);
        chk({xen, xgnt}, 2'b10);
        xreq <= 1'b1;
        put(1'b0, 16'h0002, 16'h0000);
        repeat (2) @(negedge clk_sys);
        chk({xen, xgnt, cfg}, 18'h01f02);
        t_rpin(1'b0, 16'h0000);
        t_rpin(1'b1, 16'h0200);
        put(1'b0, 16'h0004, 16'h0001);
        run <= 1'b0;
        repeat (60) @(negedge clk_sys);
        chk({pll, poff}, 2'b01);
        run <= 1'b1;
        put(1'b0, 16'h0004, 16'h0000);
        run <= 1'b0;
        repeat (18) @(negedge clk_sys);
        chk(pll, 1'b0);
        repeat (8) @(negedge clk_sys);
        chk({pll, poff}, 2'b10);
        run <= 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(pll, 1'b1);
        t_cs(1'b0, 5'h0a, 5'h1f);
        t_cs(1'b1, 5'h15, 5'h0a);
        kick(4'h4);
        chk(pd, 1'b0);
        nmi_b <= 1'b0;
        kick(4'h4);
        chk(pd, 1'b1);
        fint <= 8'h01;
        repeat (5) @(negedge clk_sys);
        chk(pd, 1'b1);
        do_reset();
        chk(pd, 1'b0);
        chk(pll, 1'b0);
        nmi_b <= 1'b1;
        put(1'b0, 16'h0005, 16'h0001);
        kick(4'h4);
        chk(pd, 1'b0);
        fint <= 8'h02;
        kick(4'h4);
        chk(pd, 1'b1);
        fint <= 8'h03;
        @(negedge clk_sys);
        chk(pd, 1'b0);
        kick(4'h8);
        chk(rob, 1'b1);
        put(1'b1, SYSC_CFG_OFS, 16'hffdf);
        put(1'b0, 16'h0005, 16'h0000);
        chk(cfg, 16'h0020);
        rd(SYSC_STATUS_OFS);
        chk(rv, 16'h0011);
        wrap_up();
    end

    initial begin
        #2000000;
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
